// ### hw/xie_exec.sv
// Purpose: decode and execute xor-immediate, swap, widen and illegal opcodes
// Assumes: one word per fetch, memory answers reads in the same cycle that mem_rd_o is high
// Notes: effective address calculation is outside; mem_addr_o is base reg
// Notes on behaviour
// - xor immediate into destination at size
// - xor result sets N Z, clears V C
// - size field 00 byte 01 word 10 long
// - immediate taken from following extension words
// - destination must be data alterable mode
// - opcode 0A3C xors byte into condition codes
// - flag bits toggle per immediate bit
// - status word xor needs supervisor state
// - supervisor xor affects every status bit
// - opcode 0A7C plus one 16-bit word
// - swap exchanges full 32 bits, flags kept
// - swap modes 01000 01001 10001
// - mixed swap: first data, second address
// - widen copies sign bit upward
// - widen modes 010 and 011
// - widen sets N Z, clears V C
// - 4AFC pushes pc and status, vectors
// - other unknown opcodes treated as illegal
`timescale 1ns/1ns
module xie_exec (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [15:0] iword_i,
  input wire logic iword_valid_i,
  output logic iword_ready_o,
  output logic [31:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);
  import xie_pkg::*;

  logic [31:0] dreg_q [8];
  logic [31:0] dreg_d [8];
  logic [31:0] areg_q [8];
  logic [31:0] areg_d [8];
  logic [31:0] ssp_q, ssp_d;
  logic [15:0] sw_q, sw_d;
  logic [31:0] pc_q, pc_d;
  xie_state_t st_q, st_d;
  logic [15:0] op_q, op_d;
  logic [31:0] imm_q, imm_d;
  logic [31:0] dest_q, dest_d;
  logic [2:0] stat_q, stat_d;
  logic [2:0] mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic mrd_q, mrd_d;
  logic mwr_q, mwr_d;
  logic push_q, push_d;
  logic [31:0] alu_a, alu_res;
  logic [1:0] alu_size;
  logic alu_widen, alu_neg, alu_zero;
  logic [2:0] ev;

  // data alterable: mode 0,2-6, or 7 with reg 0/1
  function automatic logic xie_ea_ok(input logic [5:0] ea);
    xie_ea_ok = (ea[5:3] != 3'h1) && ((ea[5:3] != 3'h7) || (ea[2:0] < 3'h2));
  endfunction : xie_ea_ok

  function automatic logic xie_is_xori(input logic [15:0] w);
    xie_is_xori = (w[15:8] == XIE_XORI_HI) && (w[7:6] != 2'h3) && xie_ea_ok(w[5:0]);
  endfunction : xie_is_xori

  function automatic logic [31:0] xie_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [1:0] sz);
    if (sz == XIE_SZ_BYTE) begin
      xie_merge = {old[31:8], nw[7:0]};
    end else if (sz == XIE_SZ_WORD) begin
      xie_merge = {old[31:16], nw[15:0]};
    end else begin
      xie_merge = nw;
    end
  endfunction : xie_merge

  xie_alu u_alu (
    .a_i(alu_a),
    .b_i(imm_q),
    .size_i(alu_size),
    .widen_i(alu_widen),
    .res_o(alu_res),
    .neg_o(alu_neg),
    .zero_o(alu_zero)
  );

  assign iword_ready_o = (st_q == XIE_ST_FETCH) || (st_q == XIE_ST_EXT1) ||
                         (st_q == XIE_ST_EXT2);
  assign mem_addr_o = waddr_q;
  assign mem_wdata_o = wdata_q;
  assign mem_rd_o = mrd_q;
  assign mem_wr_o = mwr_q;
  assign reg_rdata_o = rdata_q;
  assign irq_o = |(stat_q & mask_q);

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    imm_d = imm_q;
    dest_d = dest_q;
    ssp_d = ssp_q;
    sw_d = sw_q;
    pc_d = pc_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    mrd_d = 1'b0;
    mwr_d = 1'b0;
    push_d = push_q;
    ev = 3'h0;
    alu_a = dest_q;
    alu_size = op_q[7:6];
    alu_widen = 1'b0;
    for (int i = 0; i < 8; i++) begin
      dreg_d[i] = dreg_q[i];
      areg_d[i] = areg_q[i];
    end
    case (st_q)
      XIE_ST_FETCH: begin
        if (iword_valid_i) begin
          op_d = iword_i;
          pc_d = pc_q + 32'h2;
          imm_d = 32'h0;
          if ((iword_i == XIE_OP_XOR_CCR) || (iword_i == XIE_OP_XOR_SW) ||
              xie_is_xori(iword_i)) begin
            st_d = XIE_ST_EXT1;
          end else if ((iword_i[15:12] == 4'hC) && iword_i[8] &&
                       ((iword_i[7:3] == XIE_SWAP_DD) || (iword_i[7:3] == XIE_SWAP_AA) ||
                        (iword_i[7:3] == XIE_SWAP_DA))) begin
            if (iword_i[7:3] == XIE_SWAP_DD) begin
              dreg_d[iword_i[11:9]] = dreg_q[iword_i[2:0]];
              dreg_d[iword_i[2:0]] = dreg_q[iword_i[11:9]];
            end else if (iword_i[7:3] == XIE_SWAP_AA) begin
              areg_d[iword_i[11:9]] = areg_q[iword_i[2:0]];
              areg_d[iword_i[2:0]] = areg_q[iword_i[11:9]];
            end else begin
              dreg_d[iword_i[11:9]] = areg_q[iword_i[2:0]];
              areg_d[iword_i[2:0]] = dreg_q[iword_i[11:9]];
            end
            ev = XIE_EV_DONE;
          end else if ((iword_i[15:9] == 7'h24) && (iword_i[5:3] == 3'h0) &&
                       ((iword_i[8:6] == XIE_WIDEN_W) || (iword_i[8:6] == XIE_WIDEN_L))) begin
            alu_a = dreg_q[iword_i[2:0]];
            alu_widen = 1'b1;
            alu_size = (iword_i[8:6] == XIE_WIDEN_W) ? XIE_SZ_WORD : XIE_SZ_LONG;
            dreg_d[iword_i[2:0]] = alu_res;
            sw_d[XIE_FLAG_N] = alu_neg;
            sw_d[XIE_FLAG_Z] = alu_zero;
            sw_d[XIE_FLAG_V] = 1'b0;
            sw_d[XIE_FLAG_C] = 1'b0;
            ev = XIE_EV_DONE;
          end else begin
            // 4AFC and every unknown pattern share one path
            ev = XIE_EV_ILLEGAL;
            push_d = 1'b0;
            pc_d = pc_q;
            st_d = XIE_ST_TRAP;
          end
        end
      end
      XIE_ST_EXT1: begin
        if (iword_valid_i) begin
          pc_d = pc_q + 32'h2;
          imm_d = {16'h0, iword_i};
          if (op_q == XIE_OP_XOR_CCR) begin
            sw_d[4:0] = sw_q[4:0] ^ iword_i[4:0];
            ev = XIE_EV_DONE;
            st_d = XIE_ST_FETCH;
          end else if (op_q == XIE_OP_XOR_SW) begin
            if (sw_q[XIE_SUPER_BIT]) begin
              sw_d = sw_q ^ iword_i;
              ev = XIE_EV_DONE;
              st_d = XIE_ST_FETCH;
            end else begin
              ev = XIE_EV_PRIV;
              push_d = 1'b0;
              st_d = XIE_ST_TRAP;
            end
          end else if (op_q[7:6] == XIE_SZ_LONG) begin
            imm_d = {iword_i, 16'h0};
            st_d = XIE_ST_EXT2;
          end else begin
            if (op_q[7:6] == XIE_SZ_BYTE) begin
              imm_d = {24'h0, iword_i[7:0]};
            end
            st_d = XIE_ST_MEMRD;
          end
        end
      end
      XIE_ST_EXT2: begin
        if (iword_valid_i) begin
          pc_d = pc_q + 32'h2;
          imm_d = {imm_q[31:16], iword_i};
          st_d = XIE_ST_MEMRD;
        end
      end
      XIE_ST_MEMRD: begin
        if (op_q[5:3] == 3'h0) begin
          alu_a = dreg_q[op_q[2:0]];
          dreg_d[op_q[2:0]] = xie_merge(dreg_q[op_q[2:0]], alu_res, op_q[7:6]);
          sw_d[XIE_FLAG_N] = alu_neg;
          sw_d[XIE_FLAG_Z] = alu_zero;
          sw_d[XIE_FLAG_V] = 1'b0;
          sw_d[XIE_FLAG_C] = 1'b0;
          ev = XIE_EV_DONE;
          st_d = XIE_ST_FETCH;
        end else begin
          waddr_d = areg_q[op_q[2:0]];
          mrd_d = 1'b1;
          st_d = XIE_ST_MEMWR;
        end
      end
      XIE_ST_MEMWR: begin
        // read data arrives now: memory answers in the same cycle that mem_rd_o is high
        alu_a = mem_rdata_i;
        wdata_d = xie_merge(mem_rdata_i, alu_res, op_q[7:6]);
        mwr_d = 1'b1;
        sw_d[XIE_FLAG_N] = alu_neg;
        sw_d[XIE_FLAG_Z] = alu_zero;
        sw_d[XIE_FLAG_V] = 1'b0;
        sw_d[XIE_FLAG_C] = 1'b0;
        ev = XIE_EV_DONE;
        st_d = XIE_ST_FETCH;
      end
      XIE_ST_TRAP: begin
        // two pushes: pc first, then status word; flags untouched
        ssp_d = ssp_q - 32'h4;
        waddr_d = ssp_q - 32'h4;
        mwr_d = 1'b1;
        if (!push_q) begin
          wdata_d = pc_q;
          push_d = 1'b1;
        end else begin
          wdata_d = {16'h0, sw_q};
          pc_d = (op_q == XIE_OP_XOR_SW) ? XIE_PRIV_VEC : XIE_ILLEGAL_VEC;
          sw_d[XIE_SUPER_BIT] = 1'b1;
          st_d = XIE_ST_FETCH;
        end
      end
      default: st_d = XIE_ST_FETCH;
    endcase
  end

  // status clears on read; a new event in the same cycle wins
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      if (reg_addr_i == XIE_ADR_STATUS) begin
        rdata_d = {29'h0, stat_q};
        stat_d = 3'h0;
      end else if (reg_addr_i == XIE_ADR_MASK) begin
        rdata_d = {29'h0, mask_q};
      end else if (reg_addr_i == XIE_ADR_SW) begin
        rdata_d = {16'h0, sw_q};
      end else begin
        rdata_d = pc_q;
      end
    end
    if (reg_wr_i && (reg_addr_i == XIE_ADR_MASK)) begin
      mask_d = reg_wdata_i[2:0];
    end
    stat_d = stat_d | ev;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= XIE_ST_FETCH;
      op_q <= 16'h0;
      imm_q <= 32'h0;
      dest_q <= 32'h0;
      ssp_q <= XIE_SSP_RESET;
      sw_q <= XIE_SW_RESET;
      pc_q <= 32'h0;
      waddr_q <= 32'h0;
      wdata_q <= 32'h0;
      mrd_q <= 1'b0;
      mwr_q <= 1'b0;
      push_q <= 1'b0;
      stat_q <= 3'h0;
      mask_q <= 3'h0;
      rdata_q <= 32'h0;
      for (int i = 0; i < 8; i++) begin
        dreg_q[i] <= 32'h0;
        areg_q[i] <= 32'h0;
      end
    end else if (ce_i) begin
      st_q <= st_d;
      op_q <= op_d;
      imm_q <= imm_d;
      dest_q <= dest_d;
      ssp_q <= ssp_d;
      sw_q <= sw_d;
      pc_q <= pc_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      mrd_q <= mrd_d;
      mwr_q <= mwr_d;
      push_q <= push_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      for (int i = 0; i < 8; i++) begin
        dreg_q[i] <= dreg_d[i];
        areg_q[i] <= areg_d[i];
      end
    end
  end

  sequence s_ccr_fetch;
    st_q == XIE_ST_EXT1 && op_q == XIE_OP_XOR_CCR && iword_valid_i && ce_i;
  endsequence

  a_ccr_toggle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_ccr_fetch |=> sw_q[4:0] == ($past(sw_q[4:0]) ^ $past(iword_i[4:0])))
    else $error("condition code xor wrong");
  a_ccr_upper: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_ccr_fetch |=> sw_q[15:5] == $past(sw_q[15:5]))
    else $error("upper status changed by ccr xor");
  a_priv_trap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_q == XIE_ST_EXT1 && op_q == XIE_OP_XOR_SW && !sw_q[XIE_SUPER_BIT] && iword_valid_i
     && ce_i) |=> st_q == XIE_ST_TRAP && sw_q == $past(sw_q))
    else $error("user status xor not trapped");
  a_super_xor: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_q == XIE_ST_EXT1 && op_q == XIE_OP_XOR_SW && sw_q[XIE_SUPER_BIT] && iword_valid_i
     && ce_i) |=> sw_q == ($past(sw_q) ^ $past(iword_i)))
    else $error("status word xor wrong");
  a_illegal_push: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_q == XIE_ST_FETCH && iword_valid_i && ce_i && iword_i == XIE_OP_ILLEGAL) |=>
    st_q == XIE_ST_TRAP ##1 (mwr_q && wdata_q == $past(pc_q, 2)))
    else $error("illegal opcode did not push pc");
  a_swap_dd: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_q == XIE_ST_FETCH && iword_valid_i && ce_i && iword_i[15:12] == 4'hC && iword_i[8]
     && iword_i[7:3] == XIE_SWAP_DD) |=> sw_q == $past(sw_q))
    else $error("swap changed flags");
  a_widen_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_q == XIE_ST_FETCH && iword_valid_i && ce_i && iword_i[15:9] == 7'h24 &&
     iword_i[5:3] == 3'h0 && iword_i[8:6] == XIE_WIDEN_L) |=>
    !sw_q[XIE_FLAG_V] && !sw_q[XIE_FLAG_C] && sw_q[XIE_FLAG_X] == $past(sw_q[XIE_FLAG_X]))
    else $error("widen flags wrong");
  a_bad_ea: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_q == XIE_ST_FETCH && iword_valid_i && ce_i && iword_i[15:8] == XIE_XORI_HI &&
     iword_i[5:3] == 3'h1) |=> st_q == XIE_ST_TRAP)
    else $error("address register destination accepted");
  // sticky bits may only drop through a status read
  a_stat_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !(reg_rd_i && reg_addr_i == XIE_ADR_STATUS)) |=>
    (stat_q & $past(stat_q)) == $past(stat_q))
    else $error("status bit lost without a read");
endmodule : xie_exec

// ### pkg/xie_pkg.sv
// Purpose: shared constants for the xor/swap/widen execute block
// Assumes: 16-bit instruction words, 32-bit registers
// Notes: status word bit 13 is supervisor state
package xie_pkg;
  localparam logic [15:0] XIE_OP_XOR_CCR = 16'h0A3C;
  localparam logic [15:0] XIE_OP_XOR_SW = 16'h0A7C;
  localparam logic [15:0] XIE_OP_ILLEGAL = 16'h4AFC;
  localparam logic [7:0] XIE_XORI_HI = 8'h0A;
  localparam logic [1:0] XIE_SZ_BYTE = 2'h0;
  localparam logic [1:0] XIE_SZ_WORD = 2'h1;
  localparam logic [1:0] XIE_SZ_LONG = 2'h2;
  localparam logic [4:0] XIE_SWAP_DD = 5'h08;
  localparam logic [4:0] XIE_SWAP_AA = 5'h09;
  localparam logic [4:0] XIE_SWAP_DA = 5'h11;
  localparam logic [2:0] XIE_WIDEN_W = 3'h2;
  localparam logic [2:0] XIE_WIDEN_L = 3'h3;
  localparam int XIE_FLAG_C = 0;
  localparam int XIE_FLAG_V = 1;
  localparam int XIE_FLAG_Z = 2;
  localparam int XIE_FLAG_N = 3;
  localparam int XIE_FLAG_X = 4;
  localparam int XIE_SUPER_BIT = 13;
  localparam logic [15:0] XIE_SW_RESET = 16'h2700;
  localparam logic [31:0] XIE_SSP_RESET = 32'h0000_0000;
  localparam logic [31:0] XIE_ILLEGAL_VEC = 32'h0000_0010;
  localparam logic [31:0] XIE_PRIV_VEC = 32'h0000_0020;
  localparam logic [2:0] XIE_EV_ILLEGAL = 3'h1;
  localparam logic [2:0] XIE_EV_PRIV = 3'h2;
  localparam logic [2:0] XIE_EV_DONE = 3'h4;
  localparam logic [1:0] XIE_ADR_STATUS = 2'h0;
  localparam logic [1:0] XIE_ADR_MASK = 2'h1;
  localparam logic [1:0] XIE_ADR_SW = 2'h2;
  localparam logic [1:0] XIE_ADR_PC = 2'h3;
  typedef enum logic [5:0] {
    XIE_ST_FETCH = 6'h01,
    XIE_ST_EXT1 = 6'h02,
    XIE_ST_EXT2 = 6'h04,
    XIE_ST_MEMRD = 6'h08,
    XIE_ST_MEMWR = 6'h10,
    XIE_ST_TRAP = 6'h20
  } xie_state_t;
endpackage : xie_pkg

// ### hw/xie_alu.sv
// Purpose: xor and widen datapath with flag results
// Assumes: size code from xie_pkg
// Notes: purely combinational
`timescale 1ns/1ns
module xie_alu (
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  input wire logic [1:0] size_i,
  input wire logic widen_i,
  output logic [31:0] res_o,
  output logic neg_o,
  output logic zero_o
);
  import xie_pkg::*;
  logic [31:0] raw;
  always_comb begin
    raw = widen_i ? a_i : (a_i ^ b_i);
    if (widen_i) begin
      if (size_i == XIE_SZ_WORD) begin
        raw = {a_i[31:16], {8{a_i[7]}}, a_i[7:0]};
      end else begin
        raw = {{16{a_i[15]}}, a_i[15:0]};
      end
    end
    res_o = raw;
    neg_o = raw[31];
    zero_o = (raw == 32'h0000_0000);
    if (size_i == XIE_SZ_BYTE) begin
      neg_o = raw[7];
      zero_o = (raw[7:0] == 8'h00);
    end else if (size_i == XIE_SZ_WORD) begin
      neg_o = raw[15];
      zero_o = (raw[15:0] == 16'h0000);
    end
  end
endmodule : xie_alu

// ### bench/xie_prog_model.sv
// Purpose: program and data memory model beside the xor/swap/widen block
// Assumes: one word offered per cycle, reads answered while strobe or next cycle
// Notes: idle lines show changing junk so stale data never passes
`timescale 1ns/1ns
module xie_prog_model (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic [15:0] iword_o,
  output logic iword_valid_o,
  input wire logic [31:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);
  logic [15:0] words_q[$];
  logic [31:0] mem_q[logic [31:0]];
  logic [31:0] wr_addr_q[$];
  logic [31:0] wr_data_q[$];
  logic rd_seen_q = 1'b0;
  logic [31:0] rd_addr_q = 32'h0;
  logic [31:0] junk_q = 32'h5A5A_A5A5;
  initial begin
    iword_o = 16'h0;
    iword_valid_o = 1'b0;
  end
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem_q.exists(a) ? mem_q[a] : 32'h0;
  endfunction : peek
  // words leave in program order, long immediates high half first
  always @(posedge clk_i) begin
    if (ready_i && iword_valid_o && words_q.size() > 0) begin
      void'(words_q.pop_front());
    end
    if (words_q.size() > 0) begin
      iword_o <= words_q[0];
      iword_valid_o <= 1'b1;
    end else begin
      iword_o <= ~iword_o;
      iword_valid_o <= 1'b0;
    end
    junk_q <= ~junk_q ^ 32'h1;
    rd_seen_q <= rd_i;
    rd_addr_q <= addr_i;
    if (wr_i) begin
      mem_q[addr_i] = wdata_i;
      wr_addr_q.push_back(addr_i);
      wr_data_q.push_back(wdata_i);
    end
  end
  // data held in the strobe cycle and the one after, then junk
  assign rdata_o = rd_i ? peek(addr_i) : (rd_seen_q ? peek(rd_addr_q) : junk_q);
endmodule : xie_prog_model

// ### bench/tb_top.sv
// Purpose: self-checking bench for the xor/swap/widen execute block
// Assumes: data and address registers clear to zero at reset
// Notes: registers are seen only through flags, memory traffic and pushes
`timescale 1ns/1ns
module tb_top;
  import xie_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [15:0] iword_i;
  logic iword_valid_i;
  logic iword_ready_o;
  logic [31:0] mem_addr_o;
  logic mem_rd_o;
  logic mem_wr_o;
  logic [31:0] mem_wdata_o;
  logic [31:0] mem_rdata_i;
  logic [1:0] reg_addr_i = 2'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic irq_o;
  int failures = 0;
  int cmp_count = 0;
  logic [31:0] v;
  always #5 clk_i = ~clk_i;
  xie_exec dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .iword_i(iword_i),
    .iword_valid_i(iword_valid_i), .iword_ready_o(iword_ready_o), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
  xie_prog_model pm (.clk_i(clk_i), .ready_i(iword_ready_o), .iword_o(iword_i),
    .iword_valid_o(iword_valid_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  task automatic conclude;
    $display("mismatches %0d of %0d comparisons", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      failures++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : reg_read
  // bounded wait: queue drained, then back in fetch with ready up
  task automatic run(input logic [15:0] w[$]);
    int n;
    n = 0;
    pm.wr_addr_q.delete();
    pm.wr_data_q.delete();
    foreach (w[i]) begin
      pm.words_q.push_back(w[i]);
    end
    while (pm.words_q.size() != 0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    repeat (2) @(posedge clk_i);
    while (iword_ready_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    repeat (2) @(posedge clk_i);
    #1;
    if (n >= 100) begin
      failures++;
      $display("BAD t=%0t seen=%h want=%h", $time, n, 0);
      conclude();
    end
  endtask : run
  task automatic sw_is(input logic [15:0] sw);
    logic [31:0] r;
    reg_read(XIE_ADR_SW, r);
    check(r, {16'h0, sw});
  endtask : sw_is
  task automatic mem_is(input logic [31:0] a, input logic [31:0] m, input logic [31:0] d);
    check(pm.wr_addr_q[0], a);
    check(pm.wr_data_q[0] & m, d);
  endtask : mem_is
  // trap: two pushes below sp, event bit, vector in pc, flags kept
  task automatic trap_is(input logic [15:0] w[$], input logic [31:0] sp,
                         input logic [2:0] ev, input logic [31:0] vec, input logic [15:0] sw);
    logic [31:0] r;
    reg_read(XIE_ADR_STATUS, r);
    run(w);
    reg_read(XIE_ADR_STATUS, r);
    check({30'h0, r[1:0]}, {30'h0, ev[1:0]});
    reg_read(XIE_ADR_PC, r);
    check(r, vec);
    check(32'(pm.wr_addr_q.size()), 32'h2);
    check(pm.wr_addr_q[0], sp - 32'h4);
    check(pm.wr_addr_q[1], sp - 32'h8);
    check({16'h0, pm.wr_data_q[1][15:0]}, {16'h0, sw});
    // exception entry raises supervisor state; every other bit is kept
    sw_is(sw | (16'h1 << XIE_SUPER_BIT));
  endtask : trap_is
  task automatic sc_reset;
    reg_read(XIE_ADR_SW, v);
    check(v, {16'h0, XIE_SW_RESET});
    reg_read(XIE_ADR_STATUS, v);
    check(v, 32'h0);
  endtask : sc_reset
  // back-to-back flag xors, then done event through mask and irq
  task automatic sc_ccr;
    run('{16'h0A3C, 16'h001F, 16'h0A3C, 16'h0005});
    sw_is(16'h271A);
    check({31'h0, irq_o}, 32'h0);
    reg_write(XIE_ADR_MASK, 32'h4);
    reg_read(XIE_ADR_MASK, v);
    check(v, 32'h4);
    check({31'h0, irq_o}, 32'h1);
    reg_read(XIE_ADR_STATUS, v);
    check(v & 32'h4, 32'h4);
    check({31'h0, irq_o}, 32'h0);
  endtask : sc_ccr
  // widen then swap through all three modes; A1 ends at the widened value
  task automatic sc_widen_swap;
    run('{16'h0A80, 16'h0000, 16'h8080});
    sw_is(16'h2710);
    run('{16'h4880});
    sw_is(16'h2718);
    run('{16'h48C0, 16'hC141, 16'hC388, 16'hC149});
    sw_is(16'h2718);
    pm.mem_q[32'hFFFF_FF80] = 32'h0000_1234;
    pm.mem_q[32'h0] = 32'h1234_5678;
    run('{16'h0A51, 16'h1234});
    mem_is(32'hFFFF_FF80, 32'h0000_FFFF, 32'h0);
    sw_is(16'h2714);
    run('{16'h0A11, 16'h0080});
    mem_is(32'hFFFF_FF80, 32'h0000_00FF, 32'h80);
    sw_is(16'h2718);
    run('{16'h0A90, 16'h8000, 16'h0001});
    mem_is(32'h0, 32'hFFFF_FFFF, 32'h9234_5679);
    sw_is(16'h2718);
  endtask : sc_widen_swap
  task automatic sc_traps;
    trap_is('{16'h0A08}, 32'h0, XIE_EV_ILLEGAL, XIE_ILLEGAL_VEC, 16'h2718);
    reg_write(XIE_ADR_MASK, 32'h1);
    trap_is('{16'h4AFC}, 32'hFFFF_FFF8, XIE_EV_ILLEGAL, XIE_ILLEGAL_VEC, 16'h2718);
    trap_is('{16'hFFFF}, 32'hFFFF_FFF0, XIE_EV_ILLEGAL, XIE_ILLEGAL_VEC, 16'h2718);
  endtask : sc_traps
  // leave supervisor state, then the same opcode must trap untouched
  task automatic sc_priv;
    run('{16'h0A7C, 16'h2005});
    sw_is(16'h071D);
    trap_is('{16'h0A7C, 16'hFFFF}, 32'hFFFF_FFE8, XIE_EV_PRIV, XIE_PRIV_VEC, 16'h071D);
  endtask : sc_priv
  // a mask write while the enable is low must leave no trace
  task automatic sc_freeze;
    @(posedge clk_i);
    ce_i <= 1'b0;
    reg_write(XIE_ADR_MASK, 32'h0);
    ce_i <= 1'b1;
    reg_read(XIE_ADR_MASK, v);
    check(v, 32'h1);
  endtask : sc_freeze
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    sc_reset();
    sc_ccr();
    sc_widen_swap();
    sc_traps();
    sc_priv();
    sc_freeze();
    conclude();
  end
endmodule : tb_top
